/* File: dtc_pkg.sv */
// Constants, types and helpers shared by the dual timer block.
// Assumes an 8-bit special function register bus with 8-bit addresses.
package dtc_pkg;

  // Register addresses: one shared clock select, then one set per timer instance
  localparam logic [7:0] ADDR_CLKSEL = 8'hC9;
  localparam logic [7:0] ADDR_CTRL [2] = '{8'hC8, 8'hD8};
  localparam logic [7:0] ADDR_RL [2] = '{8'hCA, 8'hDA};
  localparam logic [7:0] ADDR_RH [2] = '{8'hCB, 8'hDB};
  localparam logic [7:0] ADDR_CL [2] = '{8'hCC, 8'hDC};
  localparam logic [7:0] ADDR_CH [2] = '{8'hCD, 8'hDD};

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Clock select field positions in the shared select register
  localparam int SEL_FIRST_LOW_LSB = 0;
  localparam int SEL_FIRST_HIGH_LSB = 2;
  localparam int SEL_SECOND_LOW_LSB = 4;
  localparam int SEL_SECOND_HIGH_LSB = 6;

  // System clock divided by twelve
  localparam logic [3:0] DIV12_COUNT = 4'hC;

  // Byte and word wrap points
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    SRC_SYS = 2'b00,
    SRC_SYS_DIV12 = 2'b01,
    SRC_TICK = 2'b10,
    SRC_PULSE = 2'b11
  } dtc_src_e;

  // Timer control register, bit 7 down to bit 0
  typedef struct packed {
    logic high_half_flag;
    logic low_half_flag;
    logic low_flag_enable;
    logic split_select;
    logic high_capture_select;
    logic low_capture_select;
    logic high_run_enable;
    logic low_run_enable;
  } dtc_ctrl_s;

  // One register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dtc_sfr_s;

  // Count enable for one selected source
  function automatic logic src_enable(input logic [1:0] sel, input logic div12,
                                      input logic tick, input logic pulse);
    logic en;
    en = 1'b1;
    case (dtc_src_e'(sel))
      SRC_SYS: en = 1'b1;
      SRC_SYS_DIV12: en = div12;
      SRC_TICK: en = tick;
      SRC_PULSE: en = pulse;
      default: en = 1'b1;
    endcase
    return en;
  endfunction

endpackage

/* File: dtc_clk_src.sv */
// Count source enables for the four clock select fields.
// Assumes tick and pulse inputs are one-cycle enables on clk_i.
`timescale 1ns/10ps
module dtc_clk_src (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Selection and timebase enables
  input wire logic [7:0] clksel_i,
  input wire logic rtc_tick_i,
  input wire logic rtc_pulse_i,
  // Enables: first low, first high, second low, second high
  output logic [3:0] src_en_o
);

  logic [3:0] div_q;
  logic [3:0] div_d;
  logic div12_q;
  logic div_wrap;

  // Divide-by-twelve enable, all counting stays on clk_i
  assign div_wrap = (div_q == dtc_pkg::DIV12_COUNT - 4'h1);
  assign div_d = div_wrap ? 4'h0 : div_q + 4'h1;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      div_q <= 4'h0;
      div12_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      div12_q <= div_wrap; // see RULE19
    end
  end

  // see RULE14
  assign src_en_o[0] = dtc_pkg::src_enable(
    clksel_i[dtc_pkg::SEL_FIRST_LOW_LSB +: 2], div12_q, rtc_tick_i, rtc_pulse_i);
  assign src_en_o[1] = dtc_pkg::src_enable(
    clksel_i[dtc_pkg::SEL_FIRST_HIGH_LSB +: 2], div12_q, rtc_tick_i, rtc_pulse_i);
  assign src_en_o[2] = dtc_pkg::src_enable(
    clksel_i[dtc_pkg::SEL_SECOND_LOW_LSB +: 2], div12_q, rtc_tick_i, rtc_pulse_i);
  assign src_en_o[3] = dtc_pkg::src_enable(
    clksel_i[dtc_pkg::SEL_SECOND_HIGH_LSB +: 2], div12_q, rtc_tick_i, rtc_pulse_i);

endmodule

/* File: dtc_timer_pair.sv */
// Two identical 16-bit timers with capture, each splittable into two halves.
// Assumes capture events are one-cycle edge pulses on clk_i from the
// external interrupt logic, and tick/pulse enables come from a timebase.
//
// Functional notes
// RULE1: Wide timer wraps FFFF, reloads, sets high flag
// RULE2: Wide timer low byte wrap sets low flag
// RULE3: Wide capture copies counter, sets high flag
// RULE4: Wide capture word wrap sets low flag
// RULE5: Each instance uses its own external edge event
// RULE6: Stopped wide capture still captures and flags
// RULE7: Capture event observed only, never consumed
// RULE8: Split mode gives two independent byte counters
// RULE9: Split timer half reloads, sets own flag
// RULE10: Shared capture event captures both halves together
// RULE11: Split capture half flags only on capture
// RULE12: Stopped split capture half still captures
// RULE13: Mixed split halves behave as single modes
// RULE14: Two-bit field selects one of four sources
// RULE15: Shared select register field layout, high ignored wide
// RULE16: Request is high flag or enabled low flag
// RULE17: Flags cleared only by software writing zero
// RULE18: Low run starts all in wide mode
// RULE19: Sources are enables, counters on system clock
// RULE20: Hardware flag set beats software clear
`timescale 1ns/10ps
module dtc_timer_pair (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register bus
  input wire dtc_pkg::dtc_sfr_s sfr_i,
  output logic [7:0] sfr_rdata_o,
  // Count sources and capture events
  input wire logic rtc_tick_i,
  input wire logic rtc_pulse_i,
  input wire logic [1:0] cap_evt_i,
  // Interrupt requests, one per instance
  output logic [1:0] irq_o
);

  logic [7:0] clksel_q;
  logic [3:0] src_en;
  logic [7:0] rdata_q;
  logic [1:0] irq_q;
  logic [7:0] inst_rdata [2];
  logic [1:0] inst_hit;
  logic [1:0] inst_irq;
  // Read data select; unmapped addresses read zero
  wire sel_hit = (sfr_i.addr == dtc_pkg::ADDR_CLKSEL);
  wire [7:0] rd_mux = sel_hit ? clksel_q :
                      inst_hit[0] ? inst_rdata[0] :
                      inst_hit[1] ? inst_rdata[1] : 8'h00;

  // Split half next count: reload on a timer wrap, else count up
  function automatic logic [7:0] half_next(input logic [7:0] val, input logic [7:0] rld,
                                           input logic cap_mode);
    logic [7:0] nxt;
    nxt = val + 8'h01;
    if (!cap_mode && val == dtc_pkg::BYTE_MAX)
    begin
      nxt = rld;
    end
    return nxt;
  endfunction

  // Split half flag from its own wrap, timer mode only
  function automatic logic half_wrap_flag(input logic cap_mode, input logic en,
                                          input logic [7:0] val);
    return !cap_mode && en && (val == dtc_pkg::BYTE_MAX);
  endfunction

  dtc_clk_src u_src (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clksel_i(clksel_q),
    .rtc_tick_i(rtc_tick_i),
    .rtc_pulse_i(rtc_pulse_i),
    .src_en_o(src_en)
  );

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      clksel_q <= dtc_pkg::RST_BYTE;
      rdata_q <= dtc_pkg::RST_BYTE;
      irq_q <= 2'b00;
    end
    else
    begin
      if (sfr_i.wr && sel_hit)
        clksel_q <= sfr_i.wdata; // see RULE15
      // Read data only moves on a read strobe
      if (sfr_i.rd)
        rdata_q <= rd_mux;
      irq_q <= inst_irq;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign irq_o = irq_q;

  for (genvar i = 0; i < 2; i++)
  begin : g_tmr
    dtc_pkg::dtc_ctrl_s ctrl_q;
    dtc_pkg::dtc_ctrl_s ctrl_d;
    logic [7:0] cl_q;
    logic [7:0] ch_q;
    logic [7:0] rl_q;
    logic [7:0] rh_q;
    logic [7:0] cl_d;
    logic [7:0] ch_d;
    logic [7:0] rl_d;
    logic [7:0] rh_d;
    logic set_h;
    logic set_l;
    wire hit_ctrl = (sfr_i.addr == dtc_pkg::ADDR_CTRL[i]);
    wire hit_rl = (sfr_i.addr == dtc_pkg::ADDR_RL[i]);
    wire hit_rh = (sfr_i.addr == dtc_pkg::ADDR_RH[i]);
    wire hit_cl = (sfr_i.addr == dtc_pkg::ADDR_CL[i]);
    wire hit_ch = (sfr_i.addr == dtc_pkg::ADDR_CH[i]);
    // Event is only sampled; the interrupt path sees the same pulse
    wire cap = cap_evt_i[i]; // see RULE5, RULE7
    wire [15:0] cnt = {ch_q, cl_q};
    wire [15:0] cnt_inc = cnt + 16'h0001;
    // High select field ignored in wide mode
    wire en_l = ctrl_q.low_run_enable && src_en[2 * i]; // see RULE18, RULE19
    wire en_h = ctrl_q.high_run_enable && src_en[2 * i + 1]; // see RULE15
    wire word_wrap = (cnt == dtc_pkg::WORD_MAX);
    wire low_wrap = (cl_q == dtc_pkg::BYTE_MAX);

    assign inst_hit[i] = hit_ctrl || hit_rl || hit_rh || hit_cl || hit_ch;
    assign inst_rdata[i] = hit_ctrl ? ctrl_q :
                           hit_rl ? rl_q :
                           hit_rh ? rh_q :
                           hit_cl ? cl_q :
                           hit_ch ? ch_q : 8'h00;
    // see RULE16
    assign inst_irq[i] = ctrl_q.high_half_flag ||
                         (ctrl_q.low_half_flag && ctrl_q.low_flag_enable);

    always_comb
    begin
      cl_d = cl_q;
      ch_d = ch_q;
      rl_d = hit_rl && sfr_i.wr ? sfr_i.wdata : rl_q;
      rh_d = hit_rh && sfr_i.wr ? sfr_i.wdata : rh_q;
      set_h = 1'b0;
      set_l = 1'b0;
      if (!ctrl_q.split_select)
      begin
        if (en_l && ctrl_q.low_capture_select)
        begin
          {ch_d, cl_d} = cnt_inc;
          set_l = word_wrap; // see RULE4
        end
        else if (en_l)
        begin
          {ch_d, cl_d} = word_wrap ? {rh_q, rl_q} : cnt_inc; // see RULE1
          set_h = word_wrap;
          set_l = low_wrap; // see RULE2
        end
        // Captures regardless of run enable
        if (ctrl_q.low_capture_select && cap)
        begin
          rh_d = ch_q; // see RULE3, RULE6
          rl_d = cl_q;
          set_h = 1'b1;
        end
      end
      else
      begin
        // see RULE8, RULE13
        if (en_l)
          cl_d = half_next(cl_q, rl_q, ctrl_q.low_capture_select); // see RULE9
        if (en_h)
          ch_d = half_next(ch_q, rh_q, ctrl_q.high_capture_select);
        set_l = half_wrap_flag(ctrl_q.low_capture_select, en_l, cl_q); // see RULE11
        set_h = half_wrap_flag(ctrl_q.high_capture_select, en_h, ch_q);
        if (ctrl_q.low_capture_select && cap)
        begin
          rl_d = cl_q; // see RULE10, RULE12
          set_l = 1'b1;
        end
        if (ctrl_q.high_capture_select && cap)
        begin
          rh_d = ch_q; // see RULE10, RULE12
          set_h = 1'b1;
        end
      end
      // Software counter writes override counting
      if (hit_cl && sfr_i.wr)
        cl_d = sfr_i.wdata;
      if (hit_ch && sfr_i.wr)
        ch_d = sfr_i.wdata;
      ctrl_d = (hit_ctrl && sfr_i.wr) ? dtc_pkg::dtc_ctrl_s'(sfr_i.wdata) : ctrl_q; // see RULE17
      ctrl_d.high_half_flag = ctrl_d.high_half_flag || set_h; // see RULE20
      ctrl_d.low_half_flag = ctrl_d.low_half_flag || set_l; // see RULE20
    end

    always_ff @(posedge clk_i)
    begin
      if (!nrst_i)
      begin
        ctrl_q <= dtc_pkg::dtc_ctrl_s'(dtc_pkg::RST_BYTE);
        cl_q <= dtc_pkg::RST_BYTE;
        ch_q <= dtc_pkg::RST_BYTE;
        rl_q <= dtc_pkg::RST_BYTE;
        rh_q <= dtc_pkg::RST_BYTE;
      end
      else
      begin
        ctrl_q <= ctrl_d;
        cl_q <= cl_d;
        ch_q <= ch_d;
        rl_q <= rl_d;
        rh_q <= rh_d;
      end
    end
  end

endmodule

/* File: dtc_cpu_model.sv */
// Processor core model driving the register bus of the timer pair.
// Assumes each call starts on a falling clock edge; idle releases the bus.
`timescale 1ns/10ps
module dtc_cpu_model (
  // Clock
  input wire logic clk_i,
  // Register bus
  output dtc_pkg::dtc_sfr_s sfr_o,
  input wire logic [7:0] sfr_rdata_i
);
  initial
  begin
    sfr_o = '0;
  end
  // Writing zero to a flag bit clears it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    sfr_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~sfr_o.wdata};
    @(negedge clk_i);
    q = sfr_rdata_i;
  endtask
  // Released bus shows inverted leftovers
  task automatic idle();
    sfr_o = '{addr: ~sfr_o.addr, wr: 1'b0, rd: 1'b0, wdata: ~sfr_o.wdata};
    @(negedge clk_i);
  endtask
endmodule

/* File: dtc_timer_pair_chk.sv */
// Port assertions for the timer pair.
// Assumes binding into dtc_timer_pair; all checks on clk_i.
`timescale 1ns/10ps
module dtc_timer_pair_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register bus
  input wire dtc_pkg::dtc_sfr_s sfr_i,
  input wire logic [7:0] sfr_rdata_o,
  // Sources, events and requests
  input wire logic rtc_tick_i,
  input wire logic rtc_pulse_i,
  input wire logic [1:0] cap_evt_i,
  input wire logic [1:0] irq_o
);
  wire logic in_map = sfr_i.addr[7:5] == 3'h6 && sfr_i.addr[3:0] >= 4'h8
    && sfr_i.addr[3:0] <= 4'hD && sfr_i.addr != 8'hD9;
  wire logic wr0 = sfr_i.wr && sfr_i.addr == 8'hC8;
  wire logic wr1 = sfr_i.wr && sfr_i.addr == 8'hD8;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst_i |=> irq_o == 2'b00 && sfr_rdata_o == 8'h00) else $error("reset left outputs set");
  a_rdata_hold: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_i.rd && !in_map |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_clksel_back: assert property (
    sfr_i.wr && sfr_i.addr == 8'hC9 ##1 sfr_i.rd && !sfr_i.wr && sfr_i.addr == 8'hC9
    |=> sfr_rdata_o == $past(sfr_i.wdata, 2)) else $error("clock select readback wrong");
  a_high_irq: assert property (wr0 && sfr_i.wdata[7] ##1 !wr0 |-> ##1 irq_o[0])
    else $error("high flag gave no request");
  a_low_irq: assert property (
    wr0 && sfr_i.wdata[6:5] == 2'b11 ##1 !wr0 |-> ##1 irq_o[0])
    else $error("enabled low flag gave no request");
  a_clear_irq: assert property (
    wr0 && sfr_i.wdata == 8'h00 ##1 wr0 && sfr_i.wdata == 8'h00 |-> ##2 !irq_o[0])
    else $error("request stayed after clear");
  a_second_irq: assert property (
    wr1 && sfr_i.wdata[7] ##1 !wr1 |-> ##1 irq_o[1])
    else $error("second request missing");
  c_irq0: cover property ($rose(irq_o[0]));
  c_irq1: cover property ($rose(irq_o[1]));
  c_cap: cover property (cap_evt_i[0] ##[1:4] sfr_i.rd);
endmodule
bind dtc_timer_pair dtc_timer_pair_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_i(sfr_i),
  .sfr_rdata_o(sfr_rdata_o), .rtc_tick_i(rtc_tick_i), .rtc_pulse_i(rtc_pulse_i),
  .cap_evt_i(cap_evt_i), .irq_o(irq_o));

/* File: dual_timer_with_capture_tb.sv */
// Self-checking bench for the timer pair.
// Assumes dtc_cpu_model as bus master; inputs change on falling edges.
`timescale 1ns/10ps
module dual_timer_with_capture_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rtc_tick_i = 1'b0;
  logic rtc_pulse_i = 1'b0;
  logic [1:0] cap_evt_i = 2'b00;
  dtc_pkg::dtc_sfr_s sfr;
  logic [7:0] rdata;
  logic [1:0] irq;
  logic [7:0] q;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h saw %h", nm, e, a); end end
  dtc_cpu_model u_cpu (.clk_i(clk_i), .sfr_o(sfr), .sfr_rdata_i(rdata));
  dtc_timer_pair u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
    .rtc_tick_i(rtc_tick_i), .rtc_pulse_i(rtc_pulse_i), .cap_evt_i(cap_evt_i), .irq_o(irq));
  always #12.5 clk_i = ~clk_i;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_cpu.wr(a, d);
    u_cpu.idle();
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e, input string nm);
    u_cpu.rd(a, q);
    u_cpu.idle();
    `CHK(nm, e, q)
  endtask
  task automatic cap(input logic [1:0] m);
    cap_evt_i = m;
    @(negedge clk_i);
    cap_evt_i = 2'b00;
  endtask
  initial
  begin
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    r(8'hC9, 8'h00, "clksel reset");
    r(8'hC8, 8'h00, "ctrl reset");
    u_cpu.wr(8'hC9, 8'hE1);
    r(8'hC9, 8'hE1, "clksel");
    w(8'hD9, 8'h5A);
    r(8'hD9, 8'h00, "unmapped");
    $display("test registers done");
    // Wide timer, low field on divide by twelve
    w(8'hCA, 8'h34); w(8'hCB, 8'h12); w(8'hCC, 8'hFF); w(8'hCD, 8'hFF);
    w(8'hC8, 8'h01);
    repeat (14) @(negedge clk_i);
    `CHK("irq wide", 2'b01, irq)
    r(8'hC8, 8'hC1, "wide flags");
    r(8'hCD, 8'h12, "wide reload");
    w(8'hC8, 8'h41);
    `CHK("low gated", 2'b00, irq)
    w(8'hC8, 8'h00);
    r(8'hC8, 8'h00, "cleared");
    $display("test wide timer done");
    // Stopped wide capture, then running wrap
    w(8'hCC, 8'hCD); w(8'hCD, 8'hAB); w(8'hC8, 8'h04);
    cap(2'b10);
    r(8'hC8, 8'h04, "other event");
    cap(2'b01);
    r(8'hCA, 8'hCD, "cap low");
    r(8'hCB, 8'hAB, "cap high");
    r(8'hC8, 8'h84, "cap flag");
    w(8'hCC, 8'hFF); w(8'hCD, 8'hFF); w(8'hC8, 8'h05);
    repeat (14) @(negedge clk_i);
    r(8'hC8, 8'h45, "wrap flag");
    `CHK("wrap no irq", 1'b0, irq[0])
    w(8'hC8, 8'h00);
    w(8'hCC, 8'hFF); w(8'hC8, 8'h15);
    repeat (14) @(negedge clk_i);
    r(8'hC8, 8'h15, "split cap wrap");
    w(8'hC8, 8'h00);
    $display("test capture done");
    // Second instance, split capture while stopped
    w(8'hDC, 8'h3C); w(8'hDD, 8'h5A); w(8'hD8, 8'h1C);
    cap(2'b10);
    r(8'hDA, 8'h3C, "split cap low");
    r(8'hDB, 8'h5A, "split cap high");
    r(8'hD8, 8'hDC, "split flags");
    `CHK("irq second", 2'b10, irq)
    // Split timers on tick and pulse sources
    w(8'hD8, 8'h00); w(8'hDC, 8'hFF); w(8'hDD, 8'hFF); w(8'hDA, 8'h00); w(8'hDB, 8'h00);
    w(8'hD8, 8'h13);
    r(8'hD8, 8'h13, "no source");
    rtc_tick_i = 1'b1;
    @(negedge clk_i);
    rtc_tick_i = 1'b0;
    r(8'hD8, 8'h53, "tick wrap");
    rtc_pulse_i = 1'b1;
    @(negedge clk_i);
    rtc_pulse_i = 1'b0;
    r(8'hD8, 8'hD3, "pulse wrap");
    r(8'hDC, 8'h00, "split reload");
    $display("test split done");
    // Second instance: clear, software set, then low timer with stopped high capture
    u_cpu.wr(8'hD8, 8'h00);
    w(8'hD8, 8'h00);
    `CHK("second cleared", 1'b0, irq[1])
    w(8'hD8, 8'h80);
    `CHK("soft second", 1'b1, irq[1])
    w(8'hD8, 8'h00);
    w(8'hDC, 8'hFF); w(8'hDD, 8'h77); w(8'hD8, 8'h19);
    rtc_tick_i = 1'b1;
    @(negedge clk_i);
    rtc_tick_i = 1'b0;
    r(8'hD8, 8'h59, "mixed low wrap");
    `CHK("mixed gated", 1'b0, irq[1])
    cap(2'b10);
    r(8'hDB, 8'h77, "mixed cap byte");
    r(8'hD8, 8'hD9, "mixed flags");
    `CHK("mixed irq", 1'b1, irq[1])
    $display("test mixed done");
    // Wide timer on system clock, high field on an idle source
    w(8'hC9, 8'hEC);
    w(8'hCA, 8'hFE); w(8'hCB, 8'hFF); w(8'hCC, 8'hFE); w(8'hCD, 8'hFF);
    w(8'hC8, 8'h01);
    repeat (2) @(negedge clk_i);
    r(8'hC8, 8'hC1, "sys wide flags");
    w(8'hC8, 8'h00);
    r(8'hC8, 8'hC0, "set beats clear");
    w(8'hC8, 8'h80);
    `CHK("soft high", 1'b1, irq[0])
    w(8'hC8, 8'h60);
    `CHK("soft low", 1'b1, irq[0])
    u_cpu.wr(8'hC8, 8'h00);
    w(8'hC8, 8'h00);
    `CHK("irq cleared", 1'b0, irq[0])
    r(8'hC8, 8'h00, "flags cleared");
    $display("test flags done");
    conclude();
  end
endmodule
